// >>> xba_pkg.sv
// Shared constants and types for the X.21 byte-sync line adapter
`default_nettype none

package xba_pkg;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_LOOP_AND_IDENTITY_READ = 3'h0;
  localparam logic [2:0] REG_LINE_CONTROL_WRITE = 3'h2;
  localparam logic [2:0] REG_CLEAR_RESET_REGISTER = 3'h3;
  localparam logic [2:0] REG_MAINTENANCE_LOOP_WRITE = 3'h4;
  localparam logic [2:0] REG_LINE_STATUS_READ = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_LINE_C = 0;
  localparam int CTL_BYTE_ALIGN_MODE = 1;
  localparam int CTL_ALIGN_INIT_MODE = 2;
  localparam int CTL_FORCE_SPACE_N = 5;
  localparam int CTL_FORCE_MARK = 6;
  localparam int CTL_LOOP_TWO_ENABLE = 7;
  localparam int MNT_LOOP_FOUR_ENABLE = 6;
  localparam int ID_LOOP_TWO_READBACK = 0;
  localparam int ID_LOOP_FOUR_READBACK = 1;
  localparam int ID_CODE_LSB = 2;
  localparam int STS_INDICATION = 0;
  localparam int STS_ALWAYS_ONE = 1;
  localparam int STS_CLEAR_DETECT = 2;
  localparam int STS_RECEIVE_DATA = 6;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MAINTENANCE_RESET = 8'h00;
  localparam logic [4:0] CLEAR_ZERO_RUN = 5'h10;
  localparam logic [2:0] BITS_PER_BYTE_M1 = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic loop_two_enable;
    logic force_mark;
    logic force_space_n;
    logic align_init_mode;
    logic byte_align_mode;
    logic line_c;
  } xba_ctrl_t;

  typedef enum logic [2:0] {
    ALN_IDLE = 3'b001,
    ALN_ONES = 3'b010,
    ALN_DONE = 3'b100
  } xba_align_state_t;

endpackage : xba_pkg

`default_nettype wire

// >>> xba_sync_level.sv
// Two-flop level synchroniser for a vector of quasi-static bits
`default_nettype none

module xba_sync_level import xba_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // xba_sync_level

`default_nettype wire

// >>> xba_pulse_sync.sv
// Toggle-based event crossing from one clock domain to another
`default_nettype none

module xba_pulse_sync import xba_pkg::*; (
  // Source side
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_pulse,
  // Destination side
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_pulse
);

  logic src_toggle;
  logic dst_s1;
  logic dst_s2;
  logic dst_s3;

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      src_toggle <= 1'b0;
    end else if (src_pulse) begin
      src_toggle <= ~src_toggle;
    end
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      dst_s1 <= 1'b0;
      dst_s2 <= 1'b0;
      dst_s3 <= 1'b0;
    end else begin
      dst_s1 <= src_toggle;
      dst_s2 <= dst_s1;
      dst_s3 <= dst_s2;
    end
  end

  assign dst_pulse = dst_s2 ^ dst_s3;

endmodule // xba_pulse_sync

`default_nettype wire

// >>> xba_line_adapter.sv
// X.21 byte-sync line adapter: registers, line drive, clear detect, alignment
`default_nettype none

module xba_line_adapter import xba_pkg::*; #(
  parameter logic [5:0] ID_CODE = 6'h2a // Arbitrary identification value
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register access
  input wire logic [2:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Link timing from network
  input wire logic link_clk,
  input wire logic line_b,
  // X.21 line
  output logic line_t,
  output logic line_c,
  input wire logic line_r,
  input wire logic line_i,
  // Adapter serial side, timed by link_clk
  input wire logic adapter_txd,
  output logic adapter_rxd,
  // Alignment status
  output logic align_locked
);

  // ----------------------------------------------------------------
  // System-domain registers
  // ----------------------------------------------------------------
  logic [7:0] line_control_write;
  logic [7:0] maintenance_loop_write;
  logic clear_detect;
  logic clear_event_sys;
  logic [1:0] line_levels_sys;
  logic clear_access;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      line_control_write <= LINE_CONTROL_RESET;
    end else if (reg_write && reg_addr == REG_LINE_CONTROL_WRITE) begin
      line_control_write <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      maintenance_loop_write <= MAINTENANCE_RESET;
    end else if (reg_write && reg_addr == REG_MAINTENANCE_LOOP_WRITE) begin
      maintenance_loop_write <= reg_wdata;
    end
  end

  assign clear_access = (reg_read || reg_write) && reg_addr == REG_CLEAR_RESET_REGISTER;

  // Set wins over the access that clears it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clear_detect <= 1'b0;
    end else if (clear_event_sys) begin
      clear_detect <= 1'b1;
    end else if (clear_access) begin
      clear_detect <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      REG_LOOP_AND_IDENTITY_READ: begin
        next_rdata[ID_LOOP_TWO_READBACK] = line_control_write[CTL_LOOP_TWO_ENABLE];
        next_rdata[ID_LOOP_FOUR_READBACK] = maintenance_loop_write[MNT_LOOP_FOUR_ENABLE];
        next_rdata[ID_CODE_LSB +: 6] = ID_CODE;
      end
      REG_LINE_STATUS_READ: begin
        next_rdata[STS_INDICATION] = line_levels_sys[0];
        next_rdata[STS_ALWAYS_ONE] = 1'b1;
        next_rdata[STS_CLEAR_DETECT] = clear_detect;
        next_rdata[STS_RECEIVE_DATA] = line_levels_sys[1];
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link-domain reset release
  // ----------------------------------------------------------------
  logic link_rst_s1;
  logic link_rst;

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      link_rst_s1 <= 1'b1;
      link_rst <= 1'b1;
    end else begin
      link_rst_s1 <= 1'b0;
      link_rst <= link_rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Domain crossings
  // ----------------------------------------------------------------
  xba_ctrl_t ctrl_sys;
  xba_ctrl_t ctrl_link;
  logic [6:0] link_sync_out;
  logic ind_link;
  logic clear_event_link;

  always_comb begin
    ctrl_sys.loop_two_enable = line_control_write[CTL_LOOP_TWO_ENABLE];
    ctrl_sys.force_mark = line_control_write[CTL_FORCE_MARK];
    ctrl_sys.force_space_n = line_control_write[CTL_FORCE_SPACE_N];
    ctrl_sys.align_init_mode = line_control_write[CTL_ALIGN_INIT_MODE];
    ctrl_sys.byte_align_mode = line_control_write[CTL_BYTE_ALIGN_MODE];
    ctrl_sys.line_c = line_control_write[CTL_LINE_C];
  end

  xba_sync_level #(.WIDTH(7)) u_sync_to_link (
    .clk(link_clk),
    .rst(link_rst),
    .async_in({line_i, ctrl_sys}),
    .sync_out(link_sync_out)
  );

  assign ctrl_link = link_sync_out[5:0];
  assign ind_link = link_sync_out[6];

  xba_sync_level #(.WIDTH(2)) u_sync_to_sys (
    .clk(sys_clk),
    .rst(reset),
    .async_in({line_r, line_i}),
    .sync_out(line_levels_sys)
  );

  xba_pulse_sync u_clear_event (
    .src_clk(link_clk),
    .src_rst(link_rst),
    .src_pulse(clear_event_link),
    .dst_clk(sys_clk),
    .dst_rst(reset),
    .dst_pulse(clear_event_sys)
  );

  // ----------------------------------------------------------------
  // Byte timing counter
  // ----------------------------------------------------------------
  logic [2:0] byte_phase;
  logic [2:0] cur_phase;
  logic byte_boundary;

  assign byte_boundary = line_b;
  assign cur_phase = byte_boundary ? 3'h0 : byte_phase;

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      byte_phase <= 3'h0;
    end else begin
      byte_phase <= cur_phase + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Alignment of adapter data to byte timing
  // ----------------------------------------------------------------
  xba_align_state_t align_state;
  logic [2:0] tx_delay;
  logic [7:0] tx_hist;
  logic tx_tap;

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      tx_hist <= 8'h00;
    end else begin
      tx_hist <= {tx_hist[6:0], adapter_txd};
    end
  end

  // Zero delay or byte align mode off passes data straight; otherwise pick a history tap
  always_comb begin
    if (!ctrl_link.byte_align_mode || tx_delay == 3'h0) begin
      tx_tap = adapter_txd;
    end else begin
      tx_tap = tx_hist[tx_delay - 3'h1];
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      align_state <= ALN_IDLE;
      tx_delay <= 3'h0;
    end else if (!ctrl_link.align_init_mode) begin
      align_state <= ALN_IDLE;
    end else begin
      case (align_state)
        ALN_IDLE: begin
          if (adapter_txd) begin
            align_state <= ALN_ONES;
          end
        end
        ALN_ONES: begin
          if (!adapter_txd) begin
            // This bit must reach T on the next byte boundary
            tx_delay <= 3'h0 - cur_phase;
            align_state <= ALN_DONE;
          end
        end
        ALN_DONE: begin
          align_state <= ALN_DONE;
        end
        default: begin
          align_state <= ALN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      align_locked <= 1'b0;
    end else if (align_state == ALN_DONE) begin
      align_locked <= 1'b1;
    end else if (ctrl_link.align_init_mode) begin
      align_locked <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Forced marks and spaces
  // ----------------------------------------------------------------
  logic space_active;
  logic mark_active;

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      space_active <= 1'b0;
    end else if (ctrl_link.force_space_n) begin
      space_active <= 1'b0;
    end else if (!ctrl_link.byte_align_mode || cur_phase == BITS_PER_BYTE_M1) begin
      space_active <= 1'b1;
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      mark_active <= 1'b0;
    end else if (!ctrl_link.force_mark) begin
      mark_active <= 1'b0;
    end else if (!ctrl_link.byte_align_mode || cur_phase == BITS_PER_BYTE_M1) begin
      mark_active <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Line drive
  // ----------------------------------------------------------------
  logic next_line_t;

  always_comb begin
    if (ctrl_link.loop_two_enable) begin
      next_line_t = 1'b1;
    end else if (space_active) begin
      next_line_t = 1'b0;
    end else if (mark_active) begin
      next_line_t = 1'b1;
    end else begin
      next_line_t = tx_tap;
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      line_t <= 1'b1;
    end else begin
      line_t <= next_line_t;
    end
  end

  // C changes only on byte boundaries in byte align mode
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      line_c <= 1'b0;
    end else if (!ctrl_link.byte_align_mode || byte_boundary) begin
      line_c <= ctrl_link.line_c;
    end
  end

  // ----------------------------------------------------------------
  // Receive path and loop two wrap
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      adapter_rxd <= 1'b1;
    end else if (ctrl_link.loop_two_enable) begin
      adapter_rxd <= adapter_txd;
    end else begin
      adapter_rxd <= line_r;
    end
  end

  // ----------------------------------------------------------------
  // Clear detect: I low and a run of zeros on R
  // ----------------------------------------------------------------
  logic [4:0] zero_run;

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      zero_run <= 5'h00;
    end else if (ind_link || line_r) begin
      zero_run <= 5'h00;
    end else if (zero_run != CLEAR_ZERO_RUN) begin
      zero_run <= zero_run + 5'h01;
    end
  end

  // One event per run; reaching the count fires it once
  assign clear_event_link = !ind_link && !line_r && zero_run == (CLEAR_ZERO_RUN - 5'h01);

endmodule // xba_line_adapter

`default_nettype wire

// >>> xba_line_adapter_props.sv
// Port checker for the X.21 byte-sync line adapter
`default_nettype none

module xba_line_adapter_props import xba_pkg::*; #(
  parameter logic [5:0] ID_CODE = 6'h2a
) (
  // System side
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Link side
  input wire logic link_clk,
  input wire logic line_b,
  input wire logic line_t,
  input wire logic line_c,
  input wire logic line_r,
  input wire logic line_i,
  input wire logic adapter_txd,
  input wire logic adapter_rxd,
  input wire logic align_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Shadow of written bits
  // ----
  logic [7:0] ctl_s;
  logic mnt_s;
  logic [7:0] ctl_l;
  logic [3:0] age;
  logic steady;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctl_s <= 8'h00;
      mnt_s <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == REG_LINE_CONTROL_WRITE) begin
        ctl_s <= reg_wdata;
      end
      if (reg_addr == REG_MAINTENANCE_LOOP_WRITE) begin
        mnt_s <= reg_wdata[MNT_LOOP_FOUR_ENABLE];
      end
    end
  end

  // Link cycles since control last changed
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      ctl_l <= 8'h00;
      age <= 4'h0;
    end else begin
      ctl_l <= ctl_s;
      if (ctl_l != ctl_s) begin
        age <= 4'h0;
      end else if (age != 4'hc) begin
        age <= age + 4'h1;
      end
    end
  end
  assign steady = age == 4'hc;

  // ----
  // Assertions
  // ----
  loop_wrap_a: assert property (@(posedge link_clk) disable iff (reset)
    steady && ctl_l[7] |-> line_t && adapter_rxd == $past(adapter_txd))
    else $error("loop two wrap wrong");
  space_force_a: assert property (@(posedge link_clk) disable iff (reset)
    steady && ctl_l[7] == 1'b0 && ctl_l[5] == 1'b0 && ctl_l[1] == 1'b0 |-> !line_t)
    else $error("forced space missing");
  mark_force_a: assert property (@(posedge link_clk) disable iff (reset)
    steady && ctl_l[7:5] == 3'h3 && ctl_l[1] == 1'b0 |-> line_t)
    else $error("forced mark missing");
  c_line_a: assert property (@(posedge link_clk) disable iff (reset)
    steady && ctl_l[1] == 1'b0 |-> line_c == ctl_l[0])
    else $error("C line wrong");
  id_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_read && !reg_write && reg_addr == REG_LOOP_AND_IDENTITY_READ
    |=> reg_rdata == {ID_CODE, mnt_s, ctl_s[7]})
    else $error("identity read wrong");
  status_fixed_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_read && reg_addr == REG_LINE_STATUS_READ
    |=> reg_rdata[1] && reg_rdata[5:3] == 3'h0 && !reg_rdata[7])
    else $error("status fixed bits wrong");
  status_i_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_read && reg_addr == REG_LINE_STATUS_READ && !$past(reset, 3) && $stable(line_i)
    && $past(line_i, 2) == line_i && $past(line_i, 3) == line_i
    |=> reg_rdata[STS_INDICATION] == $past(line_i))
    else $error("status I bit wrong");
  status_r_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_read && reg_addr == REG_LINE_STATUS_READ && !$past(reset, 3) && $stable(line_r)
    && $past(line_r, 2) == line_r && $past(line_r, 3) == line_r
    |=> reg_rdata[STS_RECEIVE_DATA] == $past(line_r))
    else $error("status R bit wrong");
  rvalid_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_read ##1 !reg_read |-> reg_rvalid ##1 !reg_rvalid)
    else $error("read valid pulse wrong");
endmodule // xba_line_adapter_props

bind xba_line_adapter xba_line_adapter_props #(.ID_CODE(ID_CODE)) xba_line_adapter_props_i (
  .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .link_clk(link_clk), .line_b(line_b), .line_t(line_t),
  .line_c(line_c), .line_r(line_r), .line_i(line_i), .adapter_txd(adapter_txd),
  .adapter_rxd(adapter_rxd), .align_locked(align_locked));

`default_nettype wire

// >>> xba_dce_model.sv
// Behavioural network equipment facing the line adapter
`default_nettype none

module xba_dce_model import xba_pkg::*; (
  // Link timing and reset
  input wire logic link_clk,
  input wire logic reset,
  // Levels chosen by the bench
  input wire logic i_lvl,
  input wire logic r_lvl,
  // Lines toward the adapter
  output logic line_b,
  output logic line_r,
  output logic line_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase;

  // Byte timing marks bit 0 of each byte
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      phase <= 3'h0;
      line_b <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      line_b <= phase == BITS_PER_BYTE_M1;
    end
  end

  // R and I held one bit time each
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      line_r <= 1'b1;
      line_i <= 1'b1;
    end else begin
      line_r <= r_lvl;
      line_i <= i_lvl;
    end
  end
endmodule // xba_dce_model

`default_nettype wire

// >>> xba_line_adapter_bench.sv
// Self-checking bench for the X.21 byte-sync line adapter
`default_nettype none

module xba_line_adapter_bench import xba_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic wr;
    logic [2:0] a;
    logic [7:0] d;
  } xba_row_t;

  localparam logic [5:0] ID_VAL = 6'h15; // Arbitrary identification value
  logic sys_clk, reset, reg_read, reg_write, link_clk, adapter_txd, i_lvl, r_lvl;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_rvalid, line_b, line_t, line_c, line_r, line_i, adapter_rxd, align_locked;
  int fail_count = 0;
  int checks_done = 0;
  int lcnt = 0;
  int z;
  xba_row_t rows [16] = '{
    '{1'b1, 3'h2, 8'h80}, '{1'b1, 3'h4, 8'h40}, '{1'b0, 3'h0, {ID_VAL, 2'b11}},
    '{1'b1, 3'h4, 8'h00}, '{1'b0, 3'h0, {ID_VAL, 2'b01}}, '{1'b1, 3'h2, 8'h00},
    '{1'b1, 3'h4, 8'h40}, '{1'b0, 3'h0, {ID_VAL, 2'b10}}, '{1'b1, 3'h4, 8'h00},
    '{1'b0, 3'h2, 8'h00}, '{1'b0, 3'h4, 8'h00}, '{1'b0, 3'h7, 8'h00},
    '{1'b1, 3'h5, 8'hff}, '{1'b0, 3'h5, 8'h43}, '{1'b1, 3'h0, 8'hff},
    '{1'b0, 3'h0, {ID_VAL, 2'b00}}};

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge link_clk) lcnt <= lcnt + 1;

  xba_line_adapter #(.ID_CODE(ID_VAL)) xba_line_adapter_i (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .link_clk(link_clk), .line_b(line_b),
    .line_t(line_t), .line_c(line_c), .line_r(line_r), .line_i(line_i),
    .adapter_txd(adapter_txd), .adapter_rxd(adapter_rxd), .align_locked(align_locked));
  xba_dce_model xba_dce_model_i (.link_clk(link_clk), .reset(reset), .i_lvl(i_lvl),
    .r_lvl(r_lvl), .line_b(line_b), .line_r(line_r), .line_i(line_i));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge sys_clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge sys_clk);
    reg_read = 1'b0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", exp, reg_rdata);
  endtask
  task automatic lw(input int n);
    repeat (n) @(negedge link_clk);
  endtask
  // Wait for line_t to reach lvl; the change must sit on byte timing
  task automatic t_on_byte(input logic lvl);
    logic b_was;
    logic b_prev;
    b_was = 1'b0;
    b_prev = 1'b0;
    for (int k = 0; k < 40 && line_t !== lvl; k++) begin
      @(posedge link_clk);
      b_prev = b_was;
      b_was = line_b;
      #1;
    end
    chk("t_on_byte", 8'h01, {7'h00, line_t === lvl && (b_was || b_prev)});
  endtask
  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cuts a hang well past the expected run time
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  initial begin
    {reset, reg_read, reg_write, reg_addr, reg_wdata} = {3'h4, 3'h0, 8'h00};
    {adapter_txd, i_lvl, r_lvl} = 3'h7;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    lw(12);
    chk("line_t", 8'h00, {7'h00, line_t});
    chk("line_c", 8'h00, {7'h00, line_c});
    foreach (rows[k]) begin
      if (rows[k].wr) begin
        wr(rows[k].a, rows[k].d);
      end else begin
        rd(rows[k].a, rows[k].d);
      end
    end
    // ----
    // Line drive
    // ----
    wr(3'h2, 8'h20);
    adapter_txd = 1'b0;
    lw(10);
    chk("line_t", 8'h00, {7'h00, line_t});
    adapter_txd = 1'b1;
    lw(10);
    chk("line_t", 8'h01, {7'h00, line_t});
    adapter_txd = 1'b0;
    wr(3'h2, 8'h61);
    lw(10);
    chk("line_t", 8'h01, {7'h00, line_t});
    chk("line_c", 8'h01, {7'h00, line_c});
    wr(3'h2, 8'h41);
    lw(10);
    chk("line_t", 8'h00, {7'h00, line_t});
    wr(3'h2, 8'ha0);
    lw(10);
    adapter_txd = 1'b1;
    lw(3);
    chk("line_t", 8'h01, {7'h00, line_t});
    chk("adapter_rxd", 8'h01, {7'h00, adapter_rxd});
    adapter_txd = 1'b0;
    lw(3);
    chk("adapter_rxd", 8'h00, {7'h00, adapter_rxd});
    adapter_txd = 1'b1;
    wr(3'h2, 8'h02);
    t_on_byte(1'b0);
    adapter_txd = 1'b0;
    wr(3'h2, 8'h62);
    t_on_byte(1'b1);
    // ----
    // Clear detect
    // ----
    i_lvl = 1'b0;
    lw(10);
    r_lvl = 1'b0;
    lw(15);
    r_lvl = 1'b1;
    lw(10);
    rd(REG_LINE_STATUS_READ, 8'h42);
    r_lvl = 1'b0;
    lw(16);
    r_lvl = 1'b1;
    lw(20);
    rd(REG_LINE_STATUS_READ, 8'h46);
    rd(REG_LINE_STATUS_READ, 8'h46);
    rd(REG_CLEAR_RESET_REGISTER, 8'h00);
    rd(REG_LINE_STATUS_READ, 8'h42);
    r_lvl = 1'b0;
    lw(32);
    chk("adapter_rxd", 8'h00, {7'h00, adapter_rxd});
    rd(REG_LINE_STATUS_READ, 8'h06);
    wr(REG_CLEAR_RESET_REGISTER, 8'h00);
    rd(REG_LINE_STATUS_READ, 8'h02);
    {i_lvl, r_lvl} = 2'h3;
    lw(4);
    r_lvl = 1'b0;
    lw(24);
    rd(REG_LINE_STATUS_READ, 8'h03);
    // ----
    // Alignment procedure
    // ----
    r_lvl = 1'b1;
    adapter_txd = 1'b1;
    wr(3'h2, 8'h00);
    wr(3'h2, 8'h04);
    lw(20);
    chk("align_locked", 8'h00, {7'h00, align_locked});
    adapter_txd = 1'b0;
    z = lcnt;
    lw(10);
    chk("align_locked", 8'h01, {7'h00, align_locked});
    wr(3'h2, 8'h22);
    lw(10);
    while ((lcnt - z) % 8 != 0) @(negedge link_clk);
    adapter_txd = 1'b1;
    t_on_byte(1'b1);
    adapter_txd = 1'b0;
    // ----
    // Reset in mid-run
    // ----
    wr(3'h2, 8'ha1);
    wr(3'h4, 8'h40);
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    lw(12);
    rd(REG_LOOP_AND_IDENTITY_READ, {ID_VAL, 2'b00});
    chk("line_t", 8'h00, {7'h00, line_t});
    stop_test();
  end
endmodule // xba_line_adapter_bench

`default_nettype wire
